// >>> logic/fse_exc_eval.sv
// combinational exception evaluator for one floating-point operation
`timescale 1ns/10ps
module fse_exc_eval
  import fse_pkg::*;
(
  fse_exc_if.eval ex
);
  logic snan_inv; // signalling NaN counts as invalid
  logic [EXC_N-1:0] hit; // raised and enabled
  logic ovf_inf; // overflow rounds to infinity
  // ---------------------------------------------------------------
  // exception conditions, trap choice and result kind
  // ---------------------------------------------------------------
  always_comb begin
    // extended conversions are exempt unless strict mode is on
    snan_inv = ex.cond.snan & ~ex.cond.exempt & ~(ex.cond.conv_ext & ~ex.ctrl[C_STRICT]);
    ex.raised = '0;
    ex.raised[EX_INV] = snan_inv | ex.cond.inf_sub | ex.cond.zero_inf_mul |
                        ex.cond.zero_zero_div | ex.cond.inf_inf_div | ex.cond.rem_inf |
                        ex.cond.rem_zero | ex.cond.sqrt_neg | ex.cond.int_ovf |
                        ex.cond.int_bad | ex.cond.cmp_exc_nan;
    ex.raised[EX_DZ] = ex.cond.div_by_zero;
    ex.raised[EX_OF] = ex.cond.overflow;
    // the trap enable decides how much evidence underflow needs
    ex.raised[EX_UF] = ex.trap_en[EX_UF] ? ex.cond.tiny
                                         : (ex.cond.tiny & ex.cond.acc_loss);
    ex.raised[EX_IX] = ex.cond.inexact | (ex.cond.overflow & ~ex.trap_en[EX_OF]) |
                       (ex.cond.tiny & ex.cond.acc_loss & ~ex.trap_en[EX_UF]);
    hit = ex.raised & ex.trap_en;
    // an overflow or underflow trap hides the inexact trap
    if (hit[EX_OF] | hit[EX_UF]) begin
      hit[EX_IX] = 1'h0;
    end
    // lowest index wins; invalid has the highest priority
    ex.trap_sel = '0;
    for (int i = EXC_N - 1; i >= 0; i--) begin
      if (hit[i]) begin
        ex.trap_sel = '0;
        ex.trap_sel[i] = 1'h1;
      end
    end
    // overflow result depends on rounding direction and sign
    case (ex.cond.round_mode)
      RM_NEAR: ovf_inf = 1'h1;
      RM_PLUS: ovf_inf = ~ex.cond.sign;
      RM_MINUS: ovf_inf = ex.cond.sign;
      default: ovf_inf = 1'h0;
    endcase
    if (ex.raised[EX_INV]) begin
      ex.res_kind = ex.cond.int_ovf ? RK_INT_MAX : RK_QNAN;
    end else if (ex.cond.sqrt_neg_zero) begin
      ex.res_kind = RK_NEG_ZERO;
    end else if (ex.raised[EX_DZ]) begin
      ex.res_kind = RK_INF;
    end else if (ex.raised[EX_OF]) begin
      ex.res_kind = ovf_inf ? RK_INF : RK_MAX_FIN;
    end else if (ex.cond.tiny & ex.ctrl[C_FLUSH]) begin
      ex.res_kind = RK_ZERO;
    end else begin
      ex.res_kind = RK_NORMAL;
    end
  end
endmodule : fse_exc_eval

// >>> logic/fse_exc_if.sv
// carrier between the status logic and the exception evaluator
`timescale 1ns/10ps
interface fse_exc_if;
  import fse_pkg::*;
  fse_cond_t cond; // conditions of the current operation
  logic [EXC_N-1:0] trap_en; // current trap enables
  logic [EXC_N-1:0] ctrl; // current feature controls
  logic [EXC_N-1:0] raised; // exceptions that arise
  logic [EXC_N-1:0] trap_sel; // one-hot trap chosen, or zero
  fse_res_kind_t res_kind; // untrapped result kind
  modport status (output cond, output trap_en, output ctrl,
                  input raised, input trap_sel, input res_kind);
  modport eval (input cond, input trap_en, input ctrl,
                output raised, output trap_sel, output res_kind);
endinterface : fse_exc_if

// >>> logic/fse_pkg.sv
// shared constants and types of the float status and exception logic
package fse_pkg;
  // ---------------------------------------------------------------
  // exception indices inside every 5-bit exception field
  // ---------------------------------------------------------------
  localparam int EXC_N = 5;
  localparam int EX_INV = 0; // invalid operation
  localparam int EX_DZ = 1; // divide by zero
  localparam int EX_OF = 2; // overflow
  localparam int EX_UF = 3; // underflow
  localparam int EX_IX = 4; // inexact
  // ---------------------------------------------------------------
  // float_status_word layout
  // ---------------------------------------------------------------
  localparam int STICKY_LO = 0; // sticky flags, bits 4:0
  localparam int CTRL_LO = 8; // feature control, bits 12:8
  localparam int TRAP_LO = 16; // trap enables, bits 20:16
  localparam int SYS_LO = 24; // system kind byte, bits 31:24
  localparam int SYS_W = 8;
  localparam int SYS_HW_BIT = 7; // set marks a hardware implementation
  // arbitrary neutral identity value; only its top bit carries meaning
  localparam logic [SYS_W-1:0] SYS_KIND = 8'hA5;
  localparam logic [2:0] RSV_ZERO = 3'h0; // reserved gaps read as zero
  // ---------------------------------------------------------------
  // feature control bit indices inside the control field
  // ---------------------------------------------------------------
  localparam int C_FLUSH = 0; // flush_denormals, bit 8
  localparam int C_STRICT = 1; // strict_snan_convert, bit 9
  localparam int C_SYNC = 2; // sync_execution, bit 10
  localparam int C_WIDE = 3; // wide_packed_decimal, bit 11
  localparam int C_ALTC = 4; // alt_carry_compare, bit 12
  // ---------------------------------------------------------------
  // rounding modes and packed decimal word counts
  // ---------------------------------------------------------------
  localparam logic [1:0] RM_NEAR = 2'h0;
  localparam logic [1:0] RM_PLUS = 2'h1;
  localparam logic [1:0] RM_MINUS = 2'h2;
  localparam logic [1:0] RM_ZERO = 2'h3;
  localparam logic [2:0] PD_STD_WORDS = 3'h3;
  localparam logic [2:0] PD_WIDE_WORDS = 3'h4;
  // kind of result delivered when no trap is taken
  typedef enum logic [2:0] {
    RK_NORMAL = 3'b000, RK_QNAN = 3'b001, RK_INF = 3'b010, RK_MAX_FIN = 3'b011,
    RK_INT_MAX = 3'b100, RK_NEG_ZERO = 3'b101, RK_ZERO = 3'b110
  } fse_res_kind_t;
  // exception conditions reported by the datapath for one operation
  typedef struct packed {
    logic snan; // an operand is a signalling NaN
    logic exempt; // load, store or move without precision change
    logic conv_ext; // conversion to or from extended precision
    logic inf_sub; // magnitude subtraction of infinities
    logic zero_inf_mul; // zero times infinity
    logic zero_zero_div; // 0/0
    logic inf_inf_div; // inf/inf
    logic rem_inf; // remainder with infinite dividend
    logic rem_zero; // remainder with zero divisor
    logic sqrt_neg; // square root of a number below -0
    logic sqrt_neg_zero; // square root of -0
    logic int_ovf; // integer conversion overflowed
    logic int_bad; // integer conversion of infinity or NaN
    logic cmp_exc_nan; // excepting compare with a NaN operand
    logic div_by_zero; // zero divisor, finite non-zero dividend
    logic overflow; // unbounded rounded result too large
    logic tiny; // tiny non-zero result
    logic acc_loss; // denormalisation loss of accuracy
    logic inexact; // rounded result differs from exact
    logic sign; // sign of the result or operand
    logic [1:0] round_mode;
  } fse_cond_t;
  // whole state of the top module
  typedef struct packed {
    logic [EXC_N-1:0] trap_en;
    logic [EXC_N-1:0] ctrl;
    logic [EXC_N-1:0] sticky;
    logic [31:0] rdata;
    logic trap_req;
    logic [EXC_N-1:0] trap_type;
    fse_res_kind_t res_kind;
    logic res_sign;
    logic carry;
    logic busy;
    logic [2:0] pd_words;
  } fse_state_t;
endpackage : fse_pkg

// >>> logic/fse_status.sv
// float status word, sticky exception flags and trap request logic
`timescale 1ns/10ps
module fse_status
  import fse_pkg::*;
(
  input wire logic mclk, // coprocessor clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic status_write_instr, // one-cycle status write
  input wire logic [31:0] status_wdata, // data of the status write
  output logic [31:0] status_rdata, // float_status_word as read
  input wire logic op_valid, // one-cycle: op_cond is valid
  input wire fse_cond_t op_cond, // conditions of the operation
  output logic trap_req, // one-cycle trap request to the host
  output logic [EXC_N-1:0] trap_type, // one-hot exception of the trap
  output fse_res_kind_t result_kind, // untrapped result kind
  output logic result_sign, // sign for the result kind
  input wire logic cmp_valid, // one-cycle compare outcome
  input wire logic cmp_ge, // compare found greater or equal
  input wire logic cmp_unordered, // compare found a NaN operand
  output logic carry_flag, // host carry flag after compare
  input wire logic instr_issue, // host issues an instruction
  input wire logic instr_done, // instruction has completed
  output logic host_busy, // host must wait while high
  output logic [2:0] pd_words // packed decimal word count
);
  // ---------------------------------------------------------------
  // state and evaluator link
  // ---------------------------------------------------------------
  fse_state_t q; // registered state
  fse_state_t d; // next state
  fse_exc_if ex (); // link to the evaluator
  logic [EXC_N-1:0] untrapped; // exceptions that set flags

  // evaluation always uses the enables held before any same-cycle write
  assign ex.cond = op_cond;
  assign ex.trap_en = q.trap_en;
  assign ex.ctrl = q.ctrl;

  fse_exc_eval u_eval (
    .ex (ex)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    untrapped = ex.raised & ~q.trap_en;
    d.trap_req = 1'h0;
    // a status write loads enables, controls and flags
    if (status_write_instr) begin
      d.trap_en = status_wdata[TRAP_LO +: EXC_N];
      d.ctrl = status_wdata[CTRL_LO +: EXC_N];
      d.sticky = status_wdata[STICKY_LO +: EXC_N];
    end
    // an untrapped event in the write cycle still lands: set wins
    if (op_valid) begin
      d.sticky = d.sticky | untrapped;
      d.trap_req = |ex.trap_sel;
      d.trap_type = ex.trap_sel;
      d.res_kind = ex.res_kind;
      d.res_sign = op_cond.sign;
    end
    // carry meaning chosen by the alternative compare control
    if (cmp_valid) begin
      d.carry = cmp_ge | (q.ctrl[C_ALTC] & cmp_unordered);
    end
    // in synchronous mode the host waits for each instruction
    if (instr_done) begin
      d.busy = 1'h0;
    end
    if (instr_issue & q.ctrl[C_SYNC]) begin
      d.busy = 1'h1;
    end
    d.pd_words = d.ctrl[C_WIDE] ? PD_WIDE_WORDS : PD_STD_WORDS;
    // identity byte is a constant, so writes cannot reach it
    d.rdata = {SYS_KIND, RSV_ZERO, d.trap_en, RSV_ZERO, d.ctrl,
               RSV_ZERO, d.sticky};
    // reset clears the handshake side only; the status fields keep
    // whatever they hold until software writes them
    if (!resetn) begin
      d.trap_req = 1'h0;
      d.trap_type = '0;
      d.res_kind = RK_NORMAL;
      d.res_sign = 1'h0;
      d.carry = 1'h0;
      d.busy = 1'h0;
      d.pd_words = PD_STD_WORDS;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    q <= d;
  end

  // ---------------------------------------------------------------
  // outputs straight from the state register
  // ---------------------------------------------------------------
  assign status_rdata = q.rdata;
  assign trap_req = q.trap_req;
  assign trap_type = q.trap_type;
  assign result_kind = q.res_kind;
  assign result_sign = q.res_sign;
  assign carry_flag = q.carry;
  assign host_busy = q.busy;
  assign pd_words = q.pd_words;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // identity byte reads back constant, hardware bit set
  property p_sys_byte;
    $past(status_write_instr) |-> status_rdata[SYS_LO +: SYS_W] == SYS_KIND &&
                                  status_rdata[SYS_LO + SYS_HW_BIT];
  endproperty
  a_sys_byte: assert property (p_sys_byte) else $error("system kind byte changed");

  // status write fields appear one cycle later
  property p_write_fields;
    status_write_instr && !op_valid |=> status_rdata[TRAP_LO +: EXC_N] ==
        $past(status_wdata[TRAP_LO +: EXC_N]) && status_rdata[STICKY_LO +: EXC_N] ==
        $past(status_wdata[STICKY_LO +: EXC_N]);
  endproperty
  a_write_fields: assert property (p_write_fields) else $error("status write lost");

  // an untrapped invalid sets its flag and gives a NaN or int
  property p_inv_flag;
    op_valid && ex.raised[EX_INV] && !q.trap_en[EX_INV] |=>
        q.sticky[EX_INV] && !trap_type[EX_INV] &&
        (result_kind == RK_QNAN || result_kind == RK_INT_MAX);
  endproperty
  a_inv_flag: assert property (p_inv_flag) else $error("invalid flag not set");

  // a trapped exception leaves its flag alone
  property p_trap_no_flag;
    op_valid && !status_write_instr && ex.raised[EX_DZ] && q.trap_en[EX_DZ] |=>
        q.sticky[EX_DZ] == $past(q.sticky[EX_DZ]) && trap_req;
  endproperty
  a_trap_no_flag: assert property (p_trap_no_flag) else $error("trapped flag moved");

  // without a status write no sticky flag ever falls
  property p_sticky_hold;
    !status_write_instr |=> ($past(q.sticky) & ~q.sticky) == '0;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag cleared");

  // trap request follows any enabled exception; it only stays up for a new op
  property p_trap_req;
    op_valid && |(ex.raised & q.trap_en) |=> trap_req ##1 (!trap_req || $past(op_valid));
  endproperty
  a_trap_req: assert property (p_trap_req) else $error("trap request wrong");

  // an enabled overflow or underflow beats an enabled inexact of the same op
  property p_prio;
    op_valid && |(ex.raised[EX_OF +: 2] & q.trap_en[EX_OF +: 2]) && ex.raised[EX_IX] &&
        q.trap_en[EX_IX] |=> trap_req && !trap_type[EX_IX] && $onehot(trap_type);
  endproperty
  a_prio: assert property (p_prio) else $error("inexact trap won");

  // carry matches the selected compare meaning
  property p_carry;
    cmp_valid |=> carry_flag == ($past(cmp_ge) |
                                 ($past(q.ctrl[C_ALTC]) & $past(cmp_unordered)));
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");

  // a synchronous issue holds the host; only a done lets it go
  property p_sync;
    instr_issue && q.ctrl[C_SYNC] |=> host_busy ##1 (host_busy || $past(instr_done));
  endproperty
  a_sync: assert property (p_sync) else $error("host released early");

  // packed decimal word count follows the wide control
  property p_pd;
    !status_write_instr |=> pd_words == ($past(q.ctrl[C_WIDE]) ? PD_WIDE_WORDS
                                                             : PD_STD_WORDS);
  endproperty
  a_pd: assert property (p_pd) else $error("packed word count wrong");

  // untrapped divide by zero returns a signed infinity
  property p_div0;
    op_valid && op_cond.div_by_zero && !ex.raised[EX_INV] && !op_cond.sqrt_neg_zero |=>
        result_kind == RK_INF && result_sign == $past(op_cond.sign);
  endproperty
  a_div0: assert property (p_div0) else $error("divide by zero result wrong");

  // flushing a tiny plain result yields zero
  property p_flush;
    op_valid && op_cond.tiny && q.ctrl[C_FLUSH] && ex.raised[EX_INV +: 3] == '0 &&
        !op_cond.sqrt_neg_zero |=> result_kind == RK_ZERO;
  endproperty
  a_flush: assert property (p_flush) else $error("denormal not flushed");

  // scenarios worth seeing
  c_trap: cover property (op_valid ##1 trap_req);
  c_set_and_clear: cover property (op_valid && status_write_instr && |untrapped);
  c_sync_wait: cover property (instr_issue && q.ctrl[C_SYNC] ##[1:5] instr_done);
  c_alt_carry: cover property (cmp_valid && cmp_unordered && q.ctrl[C_ALTC]);
endmodule : fse_status

// >>> sim/fse_host_model.sv
// host core model that issues floating-point instructions and busy-waits
`timescale 1ns/10ps
module fse_host_model (
  input wire logic mclk, // coprocessor clock
  input wire logic go, // bench asks for one instruction
  input wire logic host_busy, // device holds the host while high
  output logic instr_issue // one-cycle issue pulse
);
  // ---------------------------------------------------------------
  // issue control
  // ---------------------------------------------------------------
  logic pend_q = 1'b0; // an instruction is waiting to go out
  initial instr_issue = 1'b0;
  // pending request is cleared at the edge that takes the issue
  always @(posedge mclk) begin
    if (go) begin
      pend_q <= 1'b1;
    end else if (instr_issue) begin
      pend_q <= 1'b0;
    end
  end
  // a busy host never issues: it waits for completion first
  always @(negedge mclk) begin
    instr_issue <= pend_q && !instr_issue && (host_busy !== 1'b1);
  end
endmodule : fse_host_model

// >>> sim/fse_status_tb.sv
// self-checking bench of the float status and exception logic
`timescale 1ns/10ps
module fse_status_tb;
  import fse_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic status_write_instr = 1'b0;
  logic [31:0] status_wdata = 32'h0;
  logic [31:0] status_rdata;
  logic op_valid = 1'b0;
  fse_cond_t op_cond = '0;
  logic trap_req;
  logic [EXC_N-1:0] trap_type;
  fse_res_kind_t result_kind;
  logic result_sign;
  logic cmp_valid = 1'b0;
  logic cmp_ge = 1'b0;
  logic cmp_unordered = 1'b0;
  logic carry_flag;
  logic instr_issue;
  logic instr_done = 1'b0;
  logic host_busy;
  logic [2:0] pd_words;
  logic go = 1'b0; // request to the host model
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0; // cycle count for the hang guard
  fse_cond_t c; // scratch condition set
  // expected kinds and cumulative sticky values per exception index
  fse_res_kind_t kinds [5] = '{RK_QNAN, RK_INF, RK_INF, RK_NORMAL, RK_NORMAL};
  logic [4:0] cum [5] = '{5'h01, 5'h03, 5'h17, 5'h1F, 5'h1F};
  always #5 mclk = ~mclk;
  fse_status fse_status_inst (.mclk(mclk), .resetn(resetn),
    .status_write_instr(status_write_instr), .status_wdata(status_wdata),
    .status_rdata(status_rdata), .op_valid(op_valid), .op_cond(op_cond),
    .trap_req(trap_req), .trap_type(trap_type), .result_kind(result_kind),
    .result_sign(result_sign), .cmp_valid(cmp_valid), .cmp_ge(cmp_ge),
    .cmp_unordered(cmp_unordered), .carry_flag(carry_flag), .instr_issue(instr_issue),
    .instr_done(instr_done), .host_busy(host_busy), .pd_words(pd_words));
  fse_host_model fse_host_model_inst (.mclk(mclk), .go(go), .host_busy(host_busy),
    .instr_issue(instr_issue));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one status write; the new word shows from the next falling edge on
  // an idle cycle follows so two writes never touch the strobe in one step
  task automatic wr(input logic [31:0] v);
    status_write_instr = 1'b1;
    status_wdata = v;
    @(negedge mclk);
    status_write_instr = 1'b0;
    @(negedge mclk);
  endtask : wr
  // one operation, its answer one cycle later, then the dropped request and the sticky field a cycle after that
  task automatic op(input fse_cond_t cd, input logic [4:0] tt, input fse_res_kind_t k,
                    input logic [4:0] stk);
    op_valid = 1'b1;
    op_cond = cd;
    @(negedge mclk);
    op_valid = 1'b0;
    chk(trap_req, |tt);
    chk(trap_type, tt);
    chk(result_kind, k);
    @(negedge mclk);
    chk(trap_req, 1'b0);
    chk(status_rdata[4:0], stk);
  endtask : op
  // condition set aimed at exception index e; untrapped overflow and underflow also raise inexact
  function automatic fse_cond_t mk(input int e);
    fse_cond_t r;
    r = '0;
    case (e)
      0: r.inf_sub = 1'b1;
      1: r.div_by_zero = 1'b1;
      2: r.overflow = 1'b1;
      3: begin
        r.tiny = 1'b1;
        r.acc_loss = 1'b1;
      end
      default: r.inexact = 1'b1;
    endcase
    return r;
  endfunction : mk
  // hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    chk(trap_req, 1'b0);
    chk(status_rdata[31:24], SYS_KIND);
    chk(status_rdata[31], 1'b1);
    // reserved gaps are written as zero, the identity byte as all ones
    wr(32'hFF1F_1F1F);
    chk(status_rdata, {SYS_KIND, 24'h1F1F1F});
    // a second reset must leave the whole word as it read after the write
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    chk(status_rdata, {SYS_KIND, 24'h1F1F1F});
    // untrapped: flags accumulate and are not cleared by later ops
    wr(32'h0);
    for (int e = 0; e < 5; e++) op(mk(e), 5'h00, kinds[e], cum[e]);
    op('0, 5'h00, RK_NORMAL, 5'h1F);
    wr(32'h0);
    chk(status_rdata, {SYS_KIND, 24'h0});
    // trapped: one-hot type, flags untouched
    wr(32'h001F_0000);
    for (int e = 0; e < 5; e++) op(mk(e), 5'h01 << e, kinds[e], 5'h00);
    c = mk(2);
    c.inexact = 1'b1;
    op(c, 5'h04, RK_INF, 5'h00);
    c = '0;
    c.tiny = 1'b1;
    c.inexact = 1'b1;
    op(c, 5'h08, RK_NORMAL, 5'h00);
    // untrapped tininess without accuracy loss raises nothing
    wr(32'h0);
    c = '0;
    c.tiny = 1'b1;
    op(c, 5'h00, RK_NORMAL, 5'h00);
    // signalling NaN checks with relaxed and strict conversion
    c.tiny = 1'b0;
    c.snan = 1'b1;
    c.conv_ext = 1'b1;
    op(c, 5'h00, RK_NORMAL, 5'h00);
    wr(32'h0000_0200);
    c.exempt = 1'b1;
    op(c, 5'h00, RK_NORMAL, 5'h00);
    c.exempt = 1'b0;
    op(c, 5'h00, RK_QNAN, 5'h01);
    // square root of minus zero and saturating integer conversion
    wr(32'h0);
    c = '0;
    c.sqrt_neg_zero = 1'b1;
    op(c, 5'h00, RK_NEG_ZERO, 5'h00);
    c = '0;
    c.int_ovf = 1'b1;
    c.sign = 1'b1;
    op(c, 5'h00, RK_INT_MAX, 5'h01);
    chk(result_sign, 1'b1);
    // untrapped overflow result by rounding mode, positive sign
    wr(32'h0);
    for (int m = 0; m < 4; m++) begin
      c = mk(2);
      c.round_mode = 2'(m);
      op(c, 5'h00, (m < 2) ? RK_INF : RK_MAX_FIN, 5'h14);
    end
    // flush to zero of a tiny result
    wr(32'h0000_0100);
    c = '0;
    c.tiny = 1'b1;
    op(c, 5'h00, RK_ZERO, 5'h00);
    // packed decimal word count
    wr(32'h0000_0800);
    chk(pd_words, PD_WIDE_WORDS);
    wr(32'h0);
    chk(pd_words, PD_STD_WORDS);
    // carry after compare for both carry definitions
    for (int i = 0; i < 8; i++) begin
      if (i == 4) wr(32'h0000_1000);
      cmp_valid = 1'b1;
      cmp_ge = i[0];
      cmp_unordered = i[1];
      @(negedge mclk);
      cmp_valid = 1'b0;
      chk(carry_flag, i[0] | (i[2] & i[1]));
      @(negedge mclk);
    end
    // synchronous execution holds the host until completion
    wr(32'h0000_0400);
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    repeat (2) @(negedge mclk);
    chk(host_busy, 1'b1);
    repeat (3) @(negedge mclk);
    chk(host_busy, 1'b1);
    instr_done = 1'b1;
    @(negedge mclk);
    instr_done = 1'b0;
    @(negedge mclk);
    chk(host_busy, 1'b0);
    // without synchronous execution an issue is ignored
    wr(32'h0);
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    repeat (3) @(negedge mclk);
    chk(host_busy, 1'b0);
    conclude();
  end
endmodule : fse_status_tb
